// ===== design/dmacp_dev.sv
/*
 * Engine end of the DMA control port: lite bus slave that hands writes
 * and reads to the engine core, engine-wide reset with staged release
 * of the clock domains, and the two channel interrupt outputs.
 * Assumes the master and the engine core run on sys_clk_i.
 */
`timescale 1ns/1ns


module dmacp_dev
    import dmacp_pkg::*;
#(
    parameter bit ASYNC_CLOCKING_OPTION = ASYNC_CLOCKING_DEF
)
(
    input  wire logic              sys_clk_i,
    input  wire logic              srst_i,
    input  wire logic              ce_i,
    input  wire logic [CH_N-1:0]   irq_req_i,
    input  wire logic [DATA_W-1:0] rd_data_i,
    output logic                   wr_valid_o,
    output logic [ADDR_W-1:0]      wr_addr_o,
    output logic [DATA_W-1:0]      wr_data_o,
    output logic                   rd_req_o,
    output logic [ADDR_W-1:0]      rd_addr_o,
    output logic                   eng_in_reset_o,
    output logic [DOM_N-1:0]       dom_ready_o,
    dmacp_if.dev                   bus
);

    typedef enum {DEV_IDLE, DEV_WACC, DEV_WRESP, DEV_RACC, DEV_RDATA}
        dmacp_dst_e;

    dmacp_dst_e        state_r;
    dmacp_dst_e        state_nxt;
    logic [DOM_N-1:0]  rel_s1_r;
    logic [DOM_N-1:0]  rel_r;
    logic              awready_r;
    logic              wready_r;
    logic              bvalid_r;
    logic [RESP_W-1:0] bresp_r;
    logic              arready_r;
    logic              rvalid_r;
    logic [DATA_W-1:0] rdata_r;
    logic [RESP_W-1:0] rresp_r;
    logic              wr_valid_r;
    logic [ADDR_W-1:0] wr_addr_r;
    logic [DATA_W-1:0] wr_data_r;
    logic              rd_req_r;
    logic [ADDR_W-1:0] rd_addr_r;
    logic              in_reset_r;
    logic [CH_N-1:0]   irq_r;

    // ------------------------------------------------------------------
    // Engine reset
    // ------------------------------------------------------------------
    // The link reset is already on this clock, so it needs no synchroniser
    wire eng_rst = srst_i || !bus.eng_rst_n;

    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            in_reset_r <= 1'b1;
        end else if (ce_i) begin
            in_reset_r <= !bus.eng_rst_n;
        end
    end

    // ------------------------------------------------------------------
    // Staged release of the fetch and channel domains
    // ------------------------------------------------------------------
    generate
        for (genvar d = 0; d < DOM_N; d++) begin : g_dom
            always_ff @(posedge sys_clk_i) begin
                if (eng_rst) begin
                    rel_s1_r[d] <= RST_FLAG;
                    rel_r[d]    <= RST_FLAG;
                end else if (ce_i) begin
                    rel_s1_r[d] <= 1'b1;
                    // Two-stage release only when domains are unrelated
                    rel_r[d]    <= ASYNC_CLOCKING_OPTION ? rel_s1_r[d]
                                                         : 1'b1;
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------------
    // Lite bus slave sequencing
    // ------------------------------------------------------------------
    // Writes win over reads when both arrive in the same cycle
    wire go_wr = bus.awvalid && bus.wvalid;
    wire go_rd = bus.arvalid && !go_wr;

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            DEV_IDLE: begin
                if (go_wr) begin
                    state_nxt = DEV_WACC;
                end else if (go_rd) begin
                    state_nxt = DEV_RACC;
                end
            end
            DEV_WACC: begin
                state_nxt = DEV_WRESP;
            end
            DEV_WRESP: begin
                if (bus.bready) begin
                    state_nxt = DEV_IDLE;
                end
            end
            DEV_RACC: begin
                state_nxt = DEV_RDATA;
            end
            DEV_RDATA: begin
                if (bus.rready) begin
                    state_nxt = DEV_IDLE;
                end
            end
            default: state_nxt = DEV_IDLE;
        endcase
    end

    wire take_wr = (state_r == DEV_IDLE) && go_wr;
    wire take_rd = (state_r == DEV_IDLE) && !go_wr && go_rd;

    always_ff @(posedge sys_clk_i) begin
        if (eng_rst) begin
            state_r   <= DEV_IDLE;
            awready_r <= RST_FLAG;
            wready_r  <= RST_FLAG;
            bvalid_r  <= RST_FLAG;
            arready_r <= RST_FLAG;
            rvalid_r  <= RST_FLAG;
        end else if (ce_i) begin
            state_r   <= state_nxt;
            awready_r <= (state_nxt == DEV_WACC);
            wready_r  <= (state_nxt == DEV_WACC);
            bvalid_r  <= (state_nxt == DEV_WRESP);
            arready_r <= (state_nxt == DEV_RACC);
            rvalid_r  <= (state_nxt == DEV_RDATA);
        end
    end

    // ------------------------------------------------------------------
    // Responses
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk_i) begin
        if (eng_rst) begin
            bresp_r <= RST_RESP;
            rresp_r <= RST_RESP;
            rdata_r <= RST_DATA;
        end else if (ce_i) begin
            if (state_r == DEV_WACC) begin
                bresp_r <= RESP_OKAY;
            end
            if (state_r == DEV_RACC) begin
                rresp_r <= RESP_OKAY;
                rdata_r <= rd_data_i;
            end
        end
    end

    // ------------------------------------------------------------------
    // Engine core side
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk_i) begin
        if (eng_rst) begin
            wr_valid_r <= RST_FLAG;
            wr_addr_r  <= RST_ADDR;
            wr_data_r  <= RST_DATA;
            rd_req_r   <= RST_FLAG;
            rd_addr_r  <= RST_ADDR;
        end else if (ce_i) begin
            wr_valid_r <= (state_r == DEV_WACC);
            rd_req_r   <= take_rd;
            if (take_wr) begin
                wr_addr_r <= bus.awaddr;
                wr_data_r <= bus.wdata;
            end
            if (take_rd) begin
                rd_addr_r <= bus.araddr;
            end
        end
    end

    // ------------------------------------------------------------------
    // Channel interrupts
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk_i) begin
        if (eng_rst) begin
            irq_r <= '0;
        end else if (ce_i) begin
            irq_r[CH_M2S] <= irq_req_i[CH_M2S] && rel_r[DOM_M2S];
            irq_r[CH_S2M] <= irq_req_i[CH_S2M] && rel_r[DOM_S2M];
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign bus.awready           = awready_r;
    assign bus.wready            = wready_r;
    assign bus.bvalid            = bvalid_r;
    assign bus.bresp             = bresp_r;
    assign bus.arready           = arready_r;
    assign bus.rvalid            = rvalid_r;
    assign bus.rdata             = rdata_r;
    assign bus.rresp             = rresp_r;
    assign bus.mem_to_stream_irq = irq_r[CH_M2S];
    assign bus.stream_to_mem_irq = irq_r[CH_S2M];
    assign wr_valid_o            = wr_valid_r;
    assign wr_addr_o             = wr_addr_r;
    assign wr_data_o             = wr_data_r;
    assign rd_req_o              = rd_req_r;
    assign rd_addr_o             = rd_addr_r;
    assign eng_in_reset_o        = in_reset_r;
    assign dom_ready_o           = rel_r;

endmodule : dmacp_dev

// ===== design/dmacp_host.sv
/*
 * Bus-master end of the DMA control port: turns single user commands
 * into lite bus write or read transfers, drives the engine reset and
 * registers the two channel interrupts.
 * Assumes the device end runs on the same clock as sys_clk_i.
 */
`timescale 1ns/1ns

module dmacp_host
    import dmacp_pkg::*;
(
    input  wire logic              sys_clk_i,
    input  wire logic              srst_i,
    input  wire logic              ce_i,
    input  wire logic              eng_rst_req_i,
    input  wire logic              cmd_valid_i,
    input  wire logic              cmd_write_i,
    input  wire logic [ADDR_W-1:0] cmd_addr_i,
    input  wire logic [DATA_W-1:0] cmd_wdata_i,
    output logic                   cmd_ready_o,
    output logic                   rsp_valid_o,
    output logic [DATA_W-1:0]      rsp_rdata_o,
    output logic [RESP_W-1:0]      rsp_resp_o,
    output logic [CH_N-1:0]        irq_o,
    dmacp_if.host                  bus
);

    typedef enum {HST_IDLE, HST_WRITE, HST_WRESP, HST_READ, HST_RDATA}
        dmacp_hst_e;

    dmacp_hst_e        state_r;
    dmacp_hst_e        state_nxt;
    logic              eng_rst_n_r;
    logic              awvalid_r;
    logic              wvalid_r;
    logic              bready_r;
    logic              arvalid_r;
    logic              rready_r;
    logic [ADDR_W-1:0] addr_r;
    logic [DATA_W-1:0] wdata_r;
    logic              cmd_ready_r;
    logic              rsp_valid_r;
    logic [DATA_W-1:0] rsp_rdata_r;
    logic [RESP_W-1:0] rsp_resp_r;
    logic [CH_N-1:0]   irq_r;

    // ------------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------------
    wire cmd_take = (state_r == HST_IDLE) && cmd_valid_i && eng_rst_n_r;
    wire aw_done  = awvalid_r && bus.awready;
    wire w_done   = wvalid_r && bus.wready;
    wire aw_left  = awvalid_r && !aw_done;
    wire w_left   = wvalid_r && !w_done;
    wire b_done   = bready_r && bus.bvalid;
    wire ar_done  = arvalid_r && bus.arready;
    wire r_done   = rready_r && bus.rvalid;

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            HST_IDLE: begin
                if (cmd_take) begin
                    state_nxt = cmd_write_i ? HST_WRITE : HST_READ;
                end
            end
            HST_WRITE: begin
                if (!aw_left && !w_left) begin
                    state_nxt = HST_WRESP;
                end
            end
            HST_WRESP: begin
                if (b_done) begin
                    state_nxt = HST_IDLE;
                end
            end
            HST_READ: begin
                if (ar_done) begin
                    state_nxt = HST_RDATA;
                end
            end
            HST_RDATA: begin
                if (r_done) begin
                    state_nxt = HST_IDLE;
                end
            end
            default: state_nxt = HST_IDLE;
        endcase
        if (!eng_rst_n_r) begin
            state_nxt = HST_IDLE;
        end
    end

    // ------------------------------------------------------------------
    // Engine reset, changed only on the control-port clock
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            eng_rst_n_r <= ENG_RST_N;
        end else if (ce_i) begin
            eng_rst_n_r <= !eng_rst_req_i;
        end
    end

    // ------------------------------------------------------------------
    // Bus channels
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            state_r   <= HST_IDLE;
            awvalid_r <= RST_FLAG;
            wvalid_r  <= RST_FLAG;
            bready_r  <= RST_FLAG;
            arvalid_r <= RST_FLAG;
            rready_r  <= RST_FLAG;
            addr_r    <= RST_ADDR;
            wdata_r   <= RST_DATA;
        end else if (ce_i) begin
            state_r   <= state_nxt;
            awvalid_r <= (cmd_take && cmd_write_i) || aw_left;
            wvalid_r  <= (cmd_take && cmd_write_i) || w_left;
            bready_r  <= (state_nxt == HST_WRESP);
            arvalid_r <= (cmd_take && !cmd_write_i) || (arvalid_r && !ar_done);
            rready_r  <= (state_nxt == HST_RDATA);
            if (!eng_rst_n_r) begin
                awvalid_r <= RST_FLAG;
                wvalid_r  <= RST_FLAG;
                arvalid_r <= RST_FLAG;
            end
            if (cmd_take) begin
                addr_r  <= cmd_addr_i;
                wdata_r <= cmd_wdata_i;
            end
        end
    end

    // ------------------------------------------------------------------
    // User side answers and interrupts
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            cmd_ready_r <= RST_FLAG;
            rsp_valid_r <= RST_FLAG;
            rsp_rdata_r <= RST_DATA;
            rsp_resp_r  <= RST_RESP;
            irq_r       <= '0;
        end else if (ce_i) begin
            cmd_ready_r <= (state_nxt == HST_IDLE) && !eng_rst_req_i;
            rsp_valid_r <= b_done || r_done;
            if (b_done) begin
                rsp_resp_r <= bus.bresp;
            end
            if (r_done) begin
                rsp_rdata_r <= bus.rdata;
                rsp_resp_r  <= bus.rresp;
            end
            irq_r[CH_M2S] <= bus.mem_to_stream_irq;
            irq_r[CH_S2M] <= bus.stream_to_mem_irq;
        end
    end

    assign bus.eng_rst_n = eng_rst_n_r;
    assign bus.awvalid   = awvalid_r;
    assign bus.awaddr    = addr_r;
    assign bus.wvalid    = wvalid_r;
    assign bus.wdata     = wdata_r;
    assign bus.bready    = bready_r;
    assign bus.arvalid   = arvalid_r;
    assign bus.araddr    = addr_r;
    assign bus.rready    = rready_r;
    assign cmd_ready_o   = cmd_ready_r;
    assign rsp_valid_o   = rsp_valid_r;
    assign rsp_rdata_o   = rsp_rdata_r;
    assign rsp_resp_o    = rsp_resp_r;
    assign irq_o         = irq_r;

endmodule : dmacp_host

// ===== design/dmacp_if.sv
/*
 * Control-port link between a bus master and the DMA engine: the
 * lite bus channels, the engine reset and the two channel interrupts.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/1ns

interface dmacp_if;
    import dmacp_pkg::*;

    logic              eng_rst_n;
    logic              awvalid;
    logic              awready;
    logic [ADDR_W-1:0] awaddr;
    logic              wvalid;
    logic              wready;
    logic [DATA_W-1:0] wdata;
    logic [RESP_W-1:0] bresp;
    logic              bvalid;
    logic              bready;
    logic              arvalid;
    logic              arready;
    logic [ADDR_W-1:0] araddr;
    logic              rvalid;
    logic              rready;
    logic [DATA_W-1:0] rdata;
    logic [RESP_W-1:0] rresp;
    logic              mem_to_stream_irq;
    logic              stream_to_mem_irq;

    modport dev (
        input  eng_rst_n, awvalid, awaddr, wvalid, wdata, bready,
        input  arvalid, araddr, rready,
        output awready, wready, bresp, bvalid, arready, rvalid, rdata,
        output rresp, mem_to_stream_irq, stream_to_mem_irq
    );

    modport host (
        output eng_rst_n, awvalid, awaddr, wvalid, wdata, bready,
        output arvalid, araddr, rready,
        input  awready, wready, bresp, bvalid, arready, rvalid, rdata,
        input  rresp, mem_to_stream_irq, stream_to_mem_irq
    );

endinterface : dmacp_if

// ===== design/dmacp_pkg.sv
/*
 * Shared constants for the DMA control-port link: bus widths, response
 * codes, reset values and the reset-release depth of the clock domains.
 * Assumes both ends and the interface import it whole.
 */
package dmacp_pkg;

    // ------------------------------------------------------------------
    // Bus widths
    // ------------------------------------------------------------------
    localparam int ADDR_W = 32;
    localparam int DATA_W = 32;
    localparam int RESP_W = 2;

    // ------------------------------------------------------------------
    // Response codes
    // ------------------------------------------------------------------
    localparam logic [RESP_W-1:0] RESP_OKAY   = 2'h0;
    localparam logic [RESP_W-1:0] RESP_EXOKAY = 2'h1;
    localparam logic [RESP_W-1:0] RESP_SLVERR = 2'h2;
    localparam logic [RESP_W-1:0] RESP_DECERR = 2'h3;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [DATA_W-1:0] RST_DATA  = 32'h0000_0000;
    localparam logic [ADDR_W-1:0] RST_ADDR  = 32'h0000_0000;
    localparam logic [RESP_W-1:0] RST_RESP  = 2'h0;
    localparam logic              RST_FLAG  = 1'b0;
    localparam logic              ENG_RST_N = 1'b0;

    // ------------------------------------------------------------------
    // Channels and clock domains
    // ------------------------------------------------------------------
    localparam int CH_N      = 2;
    localparam int CH_M2S    = 0;
    localparam int CH_S2M    = 1;
    localparam int DOM_N     = 3;
    localparam int DOM_FETCH = 0;
    localparam int DOM_M2S   = 1;
    localparam int DOM_S2M   = 2;

    // Default of the asynchronous clocking option
    localparam bit ASYNC_CLOCKING_DEF = 1'b0;

endpackage : dmacp_pkg

// ===== verification/dma_control_port_interface_tb.sv
/*
 * Self-checking bench: host and device ends joined by the link, random
 * writes and reads, interrupts and engine reset.
 * Assumes the design files and package are compiled first.
 */
`timescale 1ns/1ns

module dma_control_port_interface_tb;
    import dmacp_pkg::*;

    logic              sys_clk_i = 1'b0;
    logic              srst_i, ce_i, eng_rst_req_i;
    logic              cmd_valid_i, cmd_write_i, cmd_ready_o, rsp_valid_o;
    logic [ADDR_W-1:0] cmd_addr_i, wr_addr_o, rd_addr_o, a;
    logic [DATA_W-1:0] cmd_wdata_i, rsp_rdata_o, rd_data_i, wr_data_o, d;
    logic [RESP_W-1:0] rsp_resp_o;
    logic [CH_N-1:0]   irq_o, irq_req_i;
    logic [DOM_N-1:0]  dom_ready_o;
    logic              wr_valid_o, rd_req_o, eng_in_reset_o, w;
    int                bad_count, checks, rsp_cnt, n0, wr_cnt, rd_cnt, nw;

    dmacp_if bus_if ();

    dmacp_host u_dmacp_host (.sys_clk_i(sys_clk_i), .srst_i(srst_i),
        .ce_i(ce_i), .eng_rst_req_i(eng_rst_req_i), .cmd_valid_i(cmd_valid_i),
        .cmd_write_i(cmd_write_i), .cmd_addr_i(cmd_addr_i),
        .cmd_wdata_i(cmd_wdata_i), .cmd_ready_o(cmd_ready_o),
        .rsp_valid_o(rsp_valid_o), .rsp_rdata_o(rsp_rdata_o),
        .rsp_resp_o(rsp_resp_o), .irq_o(irq_o), .bus(bus_if));

    dmacp_dev u_dmacp_dev (.sys_clk_i(sys_clk_i), .srst_i(srst_i),
        .ce_i(ce_i), .irq_req_i(irq_req_i), .rd_data_i(rd_data_i),
        .wr_valid_o(wr_valid_o), .wr_addr_o(wr_addr_o),
        .wr_data_o(wr_data_o), .rd_req_o(rd_req_o), .rd_addr_o(rd_addr_o),
        .eng_in_reset_o(eng_in_reset_o), .dom_ready_o(dom_ready_o),
        .bus(bus_if));

    dmacp_monitor u_mon (.sys_clk_i(sys_clk_i), .srst_i(srst_i),
        .eng_rst_n(bus_if.eng_rst_n), .awvalid(bus_if.awvalid),
        .awready(bus_if.awready), .wvalid(bus_if.wvalid),
        .wready(bus_if.wready), .bresp(bus_if.bresp),
        .bvalid(bus_if.bvalid), .bready(bus_if.bready),
        .arvalid(bus_if.arvalid), .arready(bus_if.arready),
        .rvalid(bus_if.rvalid), .rready(bus_if.rready),
        .rdata(bus_if.rdata), .rresp(bus_if.rresp),
        .mem_to_stream_irq(bus_if.mem_to_stream_irq),
        .stream_to_mem_irq(bus_if.stream_to_mem_irq));

    // One clock feeds every domain, so the clock ordering holds
    always #20 sys_clk_i = ~sys_clk_i;

    // Pulse counters, sampled where the outputs are settled
    always @(negedge sys_clk_i) begin
        if (rsp_valid_o === 1'b1) rsp_cnt++;
        if (wr_valid_o === 1'b1) wr_cnt++;
        if (rd_req_o === 1'b1) rd_cnt++;
    end

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [CH_N-1:0] exp_irq(logic [CH_N-1:0] req,
                                                logic in_rst);
        return in_rst ? 2'h0 : req;
    endfunction : exp_irq

    // Domains released one edge after reset, or two when unrelated
    function automatic logic [DOM_N-1:0] exp_dom(int edges);
        return (edges > int'(ASYNC_CLOCKING_DEF)) ? 3'h7 : 3'h0;
    endfunction : exp_dom

    task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task automatic xfer(logic wr, logic [31:0] ad, logic [31:0] dt);
        int n;
        n = 0;
        cmd_valid_i = 1'b1;
        cmd_write_i = wr;
        cmd_addr_i  = ad;
        cmd_wdata_i = dt;
        while (cmd_ready_o !== 1'b1 && n < 20) begin
            @(negedge sys_clk_i);
            n++;
        end
        @(negedge sys_clk_i);
        cmd_valid_i = 1'b0;
        while (rsp_valid_o !== 1'b1 && n < 40) begin
            @(negedge sys_clk_i);
            n++;
        end
        chk("rsp_seen", 32'h1, 32'(n < 40));
    endtask : xfer

    task automatic chk_release();
        for (int e = 0; e < 6; e++) begin
            @(negedge sys_clk_i);
            chk("dom_ready", 32'(exp_dom(e)), 32'(dom_ready_o));
        end
    endtask : chk_release

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : report_and_stop

    initial begin
        #(40 * 4000);
        bad_count++;
        $display("ERROR watchdog expected finish seen timeout");
        report_and_stop();
    end

    // ------------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------------
    initial begin
        srst_i = 1'b1; ce_i = 1'b1; eng_rst_req_i = 1'b0;
        cmd_valid_i = 1'b0; cmd_write_i = 1'b0; cmd_addr_i = '0;
        cmd_wdata_i = '0; irq_req_i = 2'h3; rd_data_i = '0;
        bad_count = 0; checks = 0; nw = 0;
        void'($urandom(32'h0774));
        repeat (10) @(negedge sys_clk_i);
        chk("in_reset", 32'h1, 32'(eng_in_reset_o));
        chk("dom_ready", 32'h0, 32'(dom_ready_o));
        chk("irq", 32'(exp_irq(2'h3, 1'b1)), 32'(irq_o));
        srst_i = 1'b0;
        chk_release();
        chk("irq", 32'(exp_irq(2'h3, 1'b0)), 32'(irq_o));
        $display("test reset done");
        for (int i = 0; i < 16; i++) begin
            w = (i < 2) ? 1'b1 : 1'($urandom);
            a = (i == 0) ? 32'hffff_ffff : $urandom;
            d = (i == 1) ? 32'h0 : $urandom;
            if (!w) rd_data_i = d;
            xfer(w, a, d);
            nw += int'(w);
            chk("resp", 32'(RESP_OKAY), 32'(rsp_resp_o));
            if (w) begin
                chk("wr_addr", a, wr_addr_o);
                chk("wr_data", d, wr_data_o);
            end else begin
                chk("rd_addr", a, rd_addr_o);
                chk("rd_data", d, rsp_rdata_o);
            end
        end
        chk("wr_pulses", 32'(nw), 32'(wr_cnt));
        chk("rd_pulses", 32'(16 - nw), 32'(rd_cnt));
        $display("test transfers done");
        for (int p = 0; p < 4; p++) begin
            irq_req_i = 2'(p);
            repeat (3) @(negedge sys_clk_i);
            chk("irq", 32'(exp_irq(2'(p), 1'b0)), 32'(irq_o));
            chk("m2s", 32'(p & 1), 32'(bus_if.mem_to_stream_irq));
        end
        // Clock enable low must freeze both ends
        ce_i = 1'b0;
        irq_req_i = 2'h0;
        repeat (3) @(negedge sys_clk_i);
        chk("irq_frozen", 32'(exp_irq(2'h3, 1'b0)), 32'(irq_o));
        ce_i = 1'b1;
        repeat (3) @(negedge sys_clk_i);
        chk("irq", 32'(exp_irq(2'h0, 1'b0)), 32'(irq_o));
        $display("test interrupts done");
        eng_rst_req_i = 1'b1;
        irq_req_i = 2'h3;
        n0 = rsp_cnt;
        cmd_valid_i = 1'b1;
        repeat (5) @(negedge sys_clk_i);
        chk("eng_rst_n", 32'h0, 32'(bus_if.eng_rst_n));
        chk("in_reset", 32'h1, 32'(eng_in_reset_o));
        chk("irq", 32'(exp_irq(2'h3, 1'b1)), 32'(irq_o));
        chk("dom_ready", 32'h0, 32'(dom_ready_o));
        chk("cmd_ready", 32'h0, 32'(cmd_ready_o));
        chk("rsp_count", 32'(n0), 32'(rsp_cnt));
        cmd_valid_i = 1'b0;
        eng_rst_req_i = 1'b0;
        chk_release();
        chk("in_reset", 32'h0, 32'(eng_in_reset_o));
        xfer(1'b1, 32'h0000_0010, 32'h5a5a_a5a5);
        chk("wr_data", 32'h5a5a_a5a5, wr_data_o);
        chk("wr_pulses", 32'(nw + 1), 32'(wr_cnt));
        chk("rd_pulses", 32'(16 - nw), 32'(rd_cnt));
        $display("test engine reset done");
        report_and_stop();
    end

endmodule : dma_control_port_interface_tb

// ===== verification/dmacp_monitor.sv
/*
 * Concurrent checks on the control-port link between the two ends.
 * Assumes one clock and the link signals wired in by name.
 */
`timescale 1ns/1ns

module dmacp_monitor
    import dmacp_pkg::*;
(
    input  wire logic              sys_clk_i,
    input  wire logic              srst_i,
    input  wire logic              eng_rst_n,
    input  wire logic              awvalid,
    input  wire logic              awready,
    input  wire logic              wvalid,
    input  wire logic              wready,
    input  wire logic [RESP_W-1:0] bresp,
    input  wire logic              bvalid,
    input  wire logic              bready,
    input  wire logic              arvalid,
    input  wire logic              arready,
    input  wire logic              rvalid,
    input  wire logic              rready,
    input  wire logic [DATA_W-1:0] rdata,
    input  wire logic [RESP_W-1:0] rresp,
    input  wire logic              mem_to_stream_irq,
    input  wire logic              stream_to_mem_irq
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (srst_i);

    // ------------------------------------------------------------------
    // Handshake steps
    // ------------------------------------------------------------------
    sequence wr_take_s;
        awready && eng_rst_n;
    endsequence

    sequence rd_take_s;
        arready && eng_rst_n;
    endsequence

    // ------------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------------
    irq_reset_a: assert property (!eng_rst_n |=>
        !mem_to_stream_irq && !stream_to_mem_irq)
        else $error("interrupt high after engine reset");
    port_reset_a: assert property (!eng_rst_n |=>
        !awready && !wready && !bvalid && !arready && !rvalid)
        else $error("ready or valid high after engine reset");
    bresp_okay_a: assert property (bresp == RESP_OKAY)
        else $error("write response not okay");
    rresp_okay_a: assert property (rresp == RESP_OKAY)
        else $error("read response not okay");
    rdata_reset_a: assert property (!eng_rst_n |=> rdata == RST_DATA)
        else $error("read data not zero after reset");
    wr_pair_a: assert property (awready |->
        wready && awvalid && wvalid)
        else $error("write address taken without data");
    wr_answer_a: assert property (wr_take_s |=> bvalid)
        else $error("no write response after handshake");
    b_hold_a: assert property (bvalid && !bready && eng_rst_n
        |=> bvalid)
        else $error("write response dropped early");
    rd_answer_a: assert property (rd_take_s |=> rvalid)
        else $error("no read response after handshake");
    rd_take_a: assert property (arready |-> arvalid && !awready)
        else $error("read taken without request or beside write");
    r_hold_a: assert property (rvalid && !rready && eng_rst_n
        |=> rvalid)
        else $error("read response dropped early");

endmodule : dmacp_monitor
